// ---- pkg/gtr_consts.svh ----
// register map, field positions, reset values and defaults for genlock timing reset
`ifndef GTR_CONSTS_SVH
`define GTR_CONSTS_SVH

// register indices; byte address is four times the index
`define GTR_IDX_LINE_PERIOD   8'h17
`define GTR_IDX_FRAME_PERIOD  8'h18
`define GTR_IDX_FRAME_CTRL    8'h19
`define GTR_IDX_PULSE_RESYNC  8'h1a
`define GTR_IDX_H_DELAY       8'h1b
`define GTR_IDX_V_DELAY       8'h1c
`define GTR_IDX_STATUS        8'h30

// frame reset control fields
`define GTR_FC_HOST_MODE      0
`define GTR_FC_FRAME_SYNC     1

// pulse resync control fields
`define GTR_PR_STROBE         0
`define GTR_PR_TFID_EN        2
`define GTR_PR_AFS_EN         3

// status fields
`define GTR_ST_FRAME_ARMED    0
`define GTR_ST_RESYNC_ARMED   1
`define GTR_ST_GENLOCK        2
`define GTR_ST_REF_LEVEL      3

// reset values
`define GTR_RST_REG16         16'h0000
`define GTR_RST_DELAY         16'h0000

// per output standard default frame reset period
`define GTR_STD0_FRAME_PERIOD 16'h0001
`define GTR_STD1_FRAME_PERIOD 16'h0002
`define GTR_STD2_FRAME_PERIOD 16'h0005
`define GTR_STD3_FRAME_PERIOD 16'h0001

// ahb transfer encodings
`define GTR_HTRANS_NONSEQ_BIT 1
`define GTR_ADDR_HI_ZERO      22'h000000

`endif

// ---- pkg/gtr_pkg.sv ----
// types for genlock timing reset block
package gtr_pkg;

  // one-hot state of a host strobe waiting for the next frame
  typedef enum logic [1:0]
  {
    GTR_ARM_IDLE = 2'b01,
    GTR_ARM_WAIT = 2'b10
  } gtr_arm_t;

  // captured ahb address phase
  typedef struct packed
  {
    logic       valid;
    logic       write;
    logic [7:0] idx;
  } gtr_addr_phase_t;

  // one-cycle timing reset pulses
  typedef struct packed
  {
    logic frame_rst;
    logic line_rst;
    logic tfid_rst;
    logic afs_rst;
  } gtr_pulses_t;

endpackage

// ---- logic/gtr_timing_reset.sv ----
// genlock timing counter reset and output offset control with ahb-lite registers
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "gtr_consts.svh"

module gtr_timing_reset
#(
  parameter bit HAS_AUDIO = 1'b1
)
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // reference and standard pins
  input  wire logic        ref_frame_in,
  input  wire logic [1:0]  output_std_in,
  // output timing events, same clock
  input  wire logic        genlock_in,
  input  wire logic        frame_start_in,
  input  wire logic        field_start_in,
  input  wire logic        line_start_in,
  // timing resets and offsets
  output logic             frame_reset_out,
  output logic             line_reset_out,
  output logic             ten_field_id_reset_out,
  output logic             audio_frame_seq_reset_out,
  output logic      [15:0] h_delay_out,
  output logic      [15:0] v_delay_out
);

  // register state
  gtr_pkg::gtr_addr_phase_t addr_ph;
  gtr_pkg::gtr_addr_phase_t next_addr_ph;
  logic [15:0]              line_period;
  logic [15:0]              next_line_period;
  logic [15:0]              frame_reset_period;
  logic [15:0]              next_frame_reset_period;
  logic [15:0]              active_frame_period;
  logic [15:0]              next_active_frame_period;
  logic [1:0]               frame_reset_control;
  logic [1:0]               next_frame_reset_control;
  logic [3:0]               pulse_resync_control;
  logic [3:0]               next_pulse_resync_control;
  logic [15:0]              horizontal_timing_delay;
  logic [15:0]              next_horizontal_timing_delay;
  logic [15:0]              vertical_timing_delay;
  logic [15:0]              next_vertical_timing_delay;
  logic [31:0]              next_hrdata;
  logic                     std_loaded;
  logic                     next_std_loaded;
  logic [1:0]               std_seen;
  logic [1:0]               next_std_seen;
  logic [15:0]              std_default;
  logic [15:0]              status_word;

  // synchronisers
  logic                     ref_meta;
  logic                     ref_sync;
  logic                     ref_prev;
  logic [1:0]               std_meta;
  logic [1:0]               std_sync;

  // timing state
  gtr_pkg::gtr_arm_t        frame_arm;
  gtr_pkg::gtr_arm_t        next_frame_arm;
  gtr_pkg::gtr_arm_t        resync_arm;
  gtr_pkg::gtr_arm_t        next_resync_arm;
  gtr_pkg::gtr_pulses_t     pulses;
  gtr_pkg::gtr_pulses_t     next_pulses;
  logic                     fsync_prev;
  logic                     rsync_prev;
  logic [15:0]              frame_cnt;
  logic [15:0]              next_frame_cnt;
  logic [15:0]              line_cnt;
  logic [15:0]              next_line_cnt;
  logic [15:0]              next_h_delay;
  logic [15:0]              next_v_delay;
  logic                     fsync_edge;
  logic                     rsync_edge;
  logic                     ref_edge;

  // pin synchronisers
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      ref_prev <= 1'b0;
      std_meta <= 2'h0;
      std_sync <= 2'h0;
    end
    else
    begin
      ref_meta <= ref_frame_in;
      ref_sync <= ref_meta;
      ref_prev <= ref_sync;
      std_meta <= output_std_in;
      std_sync <= std_meta;
    end
  end

  // default period per output standard
  always_comb
  begin
    if (std_sync == 2'h0)
      std_default = `GTR_STD0_FRAME_PERIOD;
    else if (std_sync == 2'h1)
      std_default = `GTR_STD1_FRAME_PERIOD;
    else if (std_sync == 2'h2)
      std_default = `GTR_STD2_FRAME_PERIOD;
    else
      std_default = `GTR_STD3_FRAME_PERIOD;
  end

  always_comb
  begin
    status_word                              = 16'h0000;
    status_word[`GTR_ST_FRAME_ARMED]         = (frame_arm == gtr_pkg::GTR_ARM_WAIT);
    status_word[`GTR_ST_RESYNC_ARMED]        = (resync_arm == gtr_pkg::GTR_ARM_WAIT);
    status_word[`GTR_ST_GENLOCK]             = genlock_in;
    status_word[`GTR_ST_REF_LEVEL]           = ref_sync;
  end

  // bus slave and register file
  always_comb
  begin
    next_addr_ph                 = '0;
    next_line_period             = line_period;
    next_frame_reset_period      = frame_reset_period;
    next_active_frame_period     = active_frame_period;
    next_frame_reset_control     = frame_reset_control;
    next_pulse_resync_control    = pulse_resync_control;
    next_horizontal_timing_delay = horizontal_timing_delay;
    next_vertical_timing_delay   = vertical_timing_delay;
    next_std_loaded              = 1'b1;
    next_std_seen                = std_sync;
    next_hrdata                  = 32'h00000000;
    if (!std_loaded || (std_seen != std_sync))
    begin
      next_frame_reset_period  = std_default;
      next_active_frame_period = std_default;
    end
    if (addr_ph.valid && addr_ph.write)
    begin
      if (addr_ph.idx == `GTR_IDX_LINE_PERIOD)
        next_line_period = hwdata_in[15:0];
      else if (addr_ph.idx == `GTR_IDX_FRAME_PERIOD)
        next_frame_reset_period = hwdata_in[15:0];
      else if (addr_ph.idx == `GTR_IDX_FRAME_CTRL)
      begin
        next_frame_reset_control = hwdata_in[1:0];
        next_active_frame_period = frame_reset_period;
      end
      else if (addr_ph.idx == `GTR_IDX_PULSE_RESYNC)
      begin
        next_pulse_resync_control                  = hwdata_in[3:0];
        next_pulse_resync_control[1]               = 1'b0;
        // audio enable held low without audio
        next_pulse_resync_control[`GTR_PR_AFS_EN]  = HAS_AUDIO & hwdata_in[`GTR_PR_AFS_EN];
      end
      else if (addr_ph.idx == `GTR_IDX_H_DELAY)
        next_horizontal_timing_delay = hwdata_in[15:0];
      else if (addr_ph.idx == `GTR_IDX_V_DELAY)
        next_vertical_timing_delay = hwdata_in[15:0];
    end
    if (hsel_in && hready_in && htrans_in[`GTR_HTRANS_NONSEQ_BIT] &&
        (haddr_in[31:10] == `GTR_ADDR_HI_ZERO) && (haddr_in[1:0] == 2'h0))
    begin
      next_addr_ph.valid = 1'b1;
      next_addr_ph.write = hwrite_in;
      next_addr_ph.idx   = haddr_in[9:2];
      if (!hwrite_in)
      begin
        if (haddr_in[9:2] == `GTR_IDX_LINE_PERIOD)
          next_hrdata = {16'h0000, next_line_period};
        else if (haddr_in[9:2] == `GTR_IDX_FRAME_PERIOD)
          next_hrdata = {16'h0000, next_frame_reset_period};
        else if (haddr_in[9:2] == `GTR_IDX_FRAME_CTRL)
          next_hrdata = {30'h00000000, next_frame_reset_control};
        else if (haddr_in[9:2] == `GTR_IDX_PULSE_RESYNC)
          next_hrdata = {28'h0000000, next_pulse_resync_control};
        else if (haddr_in[9:2] == `GTR_IDX_H_DELAY)
          next_hrdata = {16'h0000, next_horizontal_timing_delay};
        else if (haddr_in[9:2] == `GTR_IDX_V_DELAY)
          next_hrdata = {16'h0000, next_vertical_timing_delay};
        else if (haddr_in[9:2] == `GTR_IDX_STATUS)
          next_hrdata = {16'h0000, status_word};
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      addr_ph                 <= '0;
      line_period             <= `GTR_RST_REG16;
      frame_reset_period      <= `GTR_RST_REG16;
      active_frame_period     <= `GTR_RST_REG16;
      frame_reset_control     <= 2'h0;
      pulse_resync_control    <= 4'h0;
      horizontal_timing_delay <= `GTR_RST_DELAY;
      vertical_timing_delay   <= `GTR_RST_DELAY;
      std_loaded              <= 1'b0;
      std_seen                <= 2'h0;
      hrdata_out              <= 32'h00000000;
      hreadyout_out           <= 1'b1;
      hresp_out               <= 1'b0;
    end
    else
    begin
      addr_ph                 <= next_addr_ph;
      line_period             <= next_line_period;
      frame_reset_period      <= next_frame_reset_period;
      active_frame_period     <= next_active_frame_period;
      frame_reset_control     <= next_frame_reset_control;
      pulse_resync_control    <= next_pulse_resync_control;
      horizontal_timing_delay <= next_horizontal_timing_delay;
      vertical_timing_delay   <= next_vertical_timing_delay;
      std_loaded              <= next_std_loaded;
      std_seen                <= next_std_seen;
      hrdata_out              <= next_hrdata;
      hreadyout_out           <= 1'b1;
      hresp_out               <= 1'b0;
    end
  end

  assign fsync_edge = frame_reset_control[`GTR_FC_FRAME_SYNC] & ~fsync_prev;
  assign rsync_edge = pulse_resync_control[`GTR_PR_STROBE] & ~rsync_prev;
  assign ref_edge   = ref_sync & ~ref_prev;

  // timing resets, counters and offsets
  always_comb
  begin
    next_frame_arm  = frame_arm;
    next_resync_arm = resync_arm;
    next_pulses     = '0;
    next_frame_cnt  = frame_cnt;
    next_line_cnt   = line_cnt;
    next_h_delay    = h_delay_out;
    next_v_delay    = v_delay_out;
    case (frame_arm)
      gtr_pkg::GTR_ARM_IDLE:
      begin
        if (frame_reset_control[`GTR_FC_HOST_MODE] && fsync_edge)
          next_frame_arm = gtr_pkg::GTR_ARM_WAIT;
      end
      gtr_pkg::GTR_ARM_WAIT:
      begin
        if (!frame_reset_control[`GTR_FC_HOST_MODE])
          next_frame_arm = gtr_pkg::GTR_ARM_IDLE;
        else if (frame_start_in)
        begin
          next_frame_arm        = gtr_pkg::GTR_ARM_IDLE;
          next_pulses.frame_rst = 1'b1;
          next_frame_cnt        = 16'h0000;
        end
      end
      default:
        next_frame_arm = gtr_pkg::GTR_ARM_IDLE;
    endcase
    if (genlock_in && !frame_reset_control[`GTR_FC_HOST_MODE] && ref_edge)
    begin
      // one reset every period input frames
      if ((active_frame_period == 16'h0000) ||
          (frame_cnt >= active_frame_period - 16'h0001))
      begin
        next_pulses.frame_rst = 1'b1;
        next_frame_cnt        = 16'h0000;
      end
      else
        next_frame_cnt = frame_cnt + 16'h0001;
    end
    // pulse resync, independent of other resets
    case (resync_arm)
      gtr_pkg::GTR_ARM_IDLE:
      begin
        if (rsync_edge)
          next_resync_arm = gtr_pkg::GTR_ARM_WAIT;
      end
      gtr_pkg::GTR_ARM_WAIT:
      begin
        if (frame_start_in)
        begin
          next_resync_arm = gtr_pkg::GTR_ARM_IDLE;
          next_pulses.tfid_rst = pulse_resync_control[`GTR_PR_TFID_EN];
          next_pulses.afs_rst  = pulse_resync_control[`GTR_PR_AFS_EN];
        end
      end
      default:
        next_resync_arm = gtr_pkg::GTR_ARM_IDLE;
    endcase
    if (next_pulses.frame_rst)
    begin
      next_pulses.line_rst = 1'b1;
      next_line_cnt        = 16'h0000;
    end
    else if (genlock_in && (line_period != 16'h0000) && line_start_in)
    begin
      if (line_cnt >= line_period - 16'h0001)
      begin
        next_pulses.line_rst = 1'b1;
        next_line_cnt        = 16'h0000;
      end
      else
        next_line_cnt = line_cnt + 16'h0001;
    end
    if (field_start_in)
    begin
      next_h_delay = horizontal_timing_delay;
      next_v_delay = vertical_timing_delay;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      frame_arm                 <= gtr_pkg::GTR_ARM_IDLE;
      resync_arm                <= gtr_pkg::GTR_ARM_IDLE;
      pulses                    <= '0;
      fsync_prev                <= 1'b0;
      rsync_prev                <= 1'b0;
      frame_cnt                 <= 16'h0000;
      line_cnt                  <= 16'h0000;
      h_delay_out               <= `GTR_RST_DELAY;
      v_delay_out               <= `GTR_RST_DELAY;
      frame_reset_out           <= 1'b0;
      line_reset_out            <= 1'b0;
      ten_field_id_reset_out    <= 1'b0;
      audio_frame_seq_reset_out <= 1'b0;
    end
    else
    begin
      frame_arm                 <= next_frame_arm;
      resync_arm                <= next_resync_arm;
      pulses                    <= next_pulses;
      fsync_prev                <= frame_reset_control[`GTR_FC_FRAME_SYNC];
      rsync_prev                <= pulse_resync_control[`GTR_PR_STROBE];
      frame_cnt                 <= next_frame_cnt;
      line_cnt                  <= next_line_cnt;
      h_delay_out               <= next_h_delay;
      v_delay_out               <= next_v_delay;
      frame_reset_out           <= next_pulses.frame_rst;
      line_reset_out            <= next_pulses.line_rst;
      ten_field_id_reset_out    <= next_pulses.tfid_rst;
      audio_frame_seq_reset_out <= next_pulses.afs_rst;
    end
  end

endmodule

// ---- test/gtr_timing_reset_asserts.sv ----
// port checks for the genlock timing reset block
`timescale 1ns/1ps
module gtr_timing_reset_asserts
(
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        resetn_in,
  // bus
  input wire logic        hsel_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  // timing
  input wire logic        frame_start_in,
  input wire logic        field_start_in,
  input wire logic        frame_reset_out,
  input wire logic        line_reset_out,
  input wire logic        ten_field_id_reset_out,
  input wire logic        audio_frame_seq_reset_out,
  input wire logic [15:0] h_delay_out,
  input wire logic [15:0] v_delay_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // no read taken in this cycle
  sequence s_no_read;
    !(hsel_in && hready_in && htrans_in[1] && !hwrite_in);
  endsequence

  a_ready_held: assert property (hreadyout_out)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp_out)
    else $error("hresp not okay");
  a_read_idle: assert property (s_no_read |=> hrdata_out == 32'h0000_0000)
    else $error("read data without read");
  a_frame_single: assert property (frame_reset_out |=> !frame_reset_out)
    else $error("frame reset longer than one cycle");
  a_line_with_frame: assert property (frame_reset_out |-> line_reset_out)
    else $error("line reset missing at frame reset");
  a_h_per_field: assert property (!$past(field_start_in) |-> $stable(h_delay_out))
    else $error("h delay moved outside field start");
  a_v_per_field: assert property (!$past(field_start_in) |-> $stable(v_delay_out))
    else $error("v delay moved outside field start");
  a_tfid_at_frame: assert property (ten_field_id_reset_out |-> $past(frame_start_in))
    else $error("ten field id reset off frame start");
  a_afs_at_frame: assert property (audio_frame_seq_reset_out |-> $past(frame_start_in))
    else $error("audio reset off frame start");
endmodule

bind gtr_timing_reset gtr_timing_reset_asserts u_asserts
(
  .sys_clk_in                (sys_clk_in),
  .resetn_in                 (resetn_in),
  .hsel_in                   (hsel_in),
  .htrans_in                 (htrans_in),
  .hwrite_in                 (hwrite_in),
  .hready_in                 (hready_in),
  .hrdata_out                (hrdata_out),
  .hreadyout_out             (hreadyout_out),
  .hresp_out                 (hresp_out),
  .frame_start_in            (frame_start_in),
  .field_start_in            (field_start_in),
  .frame_reset_out           (frame_reset_out),
  .line_reset_out            (line_reset_out),
  .ten_field_id_reset_out    (ten_field_id_reset_out),
  .audio_frame_seq_reset_out (audio_frame_seq_reset_out),
  .h_delay_out               (h_delay_out),
  .v_delay_out               (v_delay_out)
);

// ---- test/gtr_video_src.sv ----
// reference and output timing event source
`timescale 1ns/1ps
module gtr_video_src
(
  // clock
  input  wire logic clk_in,
  // events
  output logic      ref_frame_out,
  output logic      frame_start_out,
  output logic      field_start_out,
  output logic      line_start_out
);
  initial
  begin
    ref_frame_out   = 1'b0;
    frame_start_out = 1'b0;
    field_start_out = 1'b0;
    line_start_out  = 1'b0;
  end

  // one-cycle event: 0 frame, 1 field, else line
  task automatic pulse(input int sel);
    @(posedge clk_in);
    frame_start_out <= (sel == 0);
    field_start_out <= (sel == 1);
    line_start_out  <= (sel > 1);
    @(posedge clk_in);
    frame_start_out <= 1'b0;
    field_start_out <= 1'b0;
    line_start_out  <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask

  task automatic ref_frame();
    @(posedge clk_in);
    ref_frame_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    ref_frame_out <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the genlock timing reset block
`timescale 1ns/1ps
`include "gtr_consts.svh"
module testbench;
  logic        sys_clk_in;
  logic        resetn_in;
  logic        hsel_in;
  logic [31:0] haddr_in;
  logic [1:0]  htrans_in;
  logic        hwrite_in;
  logic [31:0] hwdata_in;
  logic [31:0] hrdata_out;
  logic        hreadyout_out;
  logic        hresp_out;
  logic        genlock_in;
  logic [1:0]  output_std_in;
  logic        ref_frame;
  logic        frame_start;
  logic        field_start;
  logic        line_start;
  logic        frame_rst;
  logic        line_rst;
  logic        tfid_rst;
  logic        afs_rst;
  logic [15:0] h_delay;
  logic [15:0] v_delay;
  logic [3:0]  en;
  int          fails;
  int          checked;
  int          cycles;
  int          n_fr;
  int          n_ln;
  int          n_tf;
  int          n_af;

  gtr_timing_reset dut
  (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .ref_frame_in(ref_frame), .output_std_in(output_std_in),
    .genlock_in(genlock_in), .frame_start_in(frame_start), .field_start_in(field_start),
    .line_start_in(line_start), .frame_reset_out(frame_rst), .line_reset_out(line_rst),
    .ten_field_id_reset_out(tfid_rst), .audio_frame_seq_reset_out(afs_rst),
    .h_delay_out(h_delay), .v_delay_out(v_delay)
  );

  gtr_video_src src
  (
    .clk_in(sys_clk_in), .ref_frame_out(ref_frame), .frame_start_out(frame_start),
    .field_start_out(field_start), .line_start_out(line_start)
  );

  initial
  begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  // pulse counters and hang guard
  always @(posedge sys_clk_in)
  begin
    n_fr <= n_fr + int'(frame_rst);
    n_ln <= n_ln + int'(line_rst);
    n_tf <= n_tf + int'(tfid_rst);
    n_af <= n_af + int'(afs_rst);
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      end_of_test();
    end
  end

  function automatic logic [31:0] adr(input logic [7:0] idx);
    return {22'h000000, idx, 2'b00};
  endfunction

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single ahb-lite transfer
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk_in);
    hsel_in   <= 1'b1;
    htrans_in <= 2'b10;
    haddr_in  <= a;
    hwrite_in <= wr;
    do
      @(posedge sys_clk_in);
    while (hreadyout_out !== 1'b1);
    hsel_in   <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= d;
    // data phase ends at the edge that samples hready high; read data taken there
    do
      @(posedge sys_clk_in);
    while (hreadyout_out !== 1'b1);
    q = hrdata_out;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, adr(idx), d, q);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic clr();
    @(negedge sys_clk_in);
    n_fr = 0;
    n_ln = 0;
    n_tf = 0;
    n_af = 0;
  endtask

  initial
  begin
    {fails, checked, cycles, n_fr, n_ln, n_tf, n_af} = '0;
    resetn_in = 1'b0;
    {hsel_in, hwrite_in, genlock_in} = '0;
    htrans_in = 2'b00;
    haddr_in = 32'h0;
    hwdata_in = 32'h0;
    output_std_in = 2'b10;
    repeat (3) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    rd(adr(`GTR_IDX_FRAME_PERIOD), 32'(`GTR_STD2_FRAME_PERIOD));
    rd(adr(`GTR_IDX_H_DELAY), 32'h0);
    rd(adr(`GTR_IDX_V_DELAY), 32'h0);
    rd(adr(`GTR_IDX_FRAME_CTRL), 32'h0);
    rd(adr(`GTR_IDX_PULSE_RESYNC), 32'h0);
    $display("reset values done");
    genlock_in <= 1'b1;
    wr(`GTR_IDX_PULSE_RESYNC, 32'hc);
    rd(adr(`GTR_IDX_PULSE_RESYNC), 32'hc);
    wr(`GTR_IDX_PULSE_RESYNC, 32'h0);
    wr(8'hff, 32'h5a5a);
    rd(32'h0000_03fc, 32'h0);
    rd(adr(`GTR_IDX_STATUS), 32'h4);
    $display("register access done");
    // delays held until the next field start
    wr(`GTR_IDX_H_DELAY, 32'h123);
    wr(`GTR_IDX_V_DELAY, 32'h45);
    chk(32'(h_delay), 32'h0);
    src.pulse(1);
    chk(32'(h_delay), 32'h123);
    chk(32'(v_delay), 32'h45);
    $display("offset test done");
    wr(`GTR_IDX_FRAME_PERIOD, 32'h0);
    wr(`GTR_IDX_FRAME_CTRL, 32'h0);
    clr();
    repeat (4) src.ref_frame();
    chk(32'(n_fr), 32'd4);
    chk(32'(n_ln), 32'd4);
    wr(`GTR_IDX_FRAME_PERIOD, 32'h3);
    clr();
    repeat (3) src.ref_frame();
    chk(32'(n_fr), 32'd3);
    wr(`GTR_IDX_FRAME_CTRL, 32'h0);
    clr();
    repeat (6) src.ref_frame();
    chk(32'(n_fr), 32'd2);
    $display("reference reset test done");
    wr(`GTR_IDX_FRAME_CTRL, 32'h1);
    clr();
    repeat (2) src.ref_frame();
    chk(32'(n_fr), 32'd0);
    wr(`GTR_IDX_FRAME_CTRL, 32'h3);
    wr(`GTR_IDX_FRAME_CTRL, 32'h1);
    clr();
    repeat (2) src.pulse(0);
    chk(32'(n_fr), 32'd1);
    wr(`GTR_IDX_LINE_PERIOD, 32'h2);
    clr();
    repeat (4) src.pulse(2);
    chk(32'(n_ln), 32'd2);
    wr(`GTR_IDX_LINE_PERIOD, 32'h0);
    $display("host reset test done");
    for (int i = 1; i < 4; i++)
    begin
      en = 4'(i << 2);
      wr(`GTR_IDX_PULSE_RESYNC, 32'(en | 4'h1));
      wr(`GTR_IDX_PULSE_RESYNC, 32'(en));
      clr();
      repeat (2) src.pulse(0);
      chk(32'(n_tf), 32'(en[2]));
      chk(32'(n_af), 32'(en[3]));
    end
    $display("resync test done");
    // second reset with another output standard
    resetn_in     <= 1'b0;
    output_std_in <= 2'b01;
    repeat (3) @(posedge sys_clk_in);
    resetn_in     <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk(32'(h_delay), 32'h0);
    chk(32'(v_delay), 32'h0);
    rd(adr(`GTR_IDX_FRAME_PERIOD), 32'(`GTR_STD1_FRAME_PERIOD));
    rd(adr(`GTR_IDX_PULSE_RESYNC), 32'h0);
    $display("second reset test done");
    end_of_test();
  end
endmodule
